// ===== hw/flash_bus_pkg.sv
// constants for the burst flash bus decoder
// assumes a host bus sampled on sys_clk and an array port outside
//
// Summary of operation
// [R1] host reads with select, output enable low
// [R2] data pins driven only while output enable low
// [R3] write cycle latches command, address and data
// [R4] command latches never alter array contents
// [R5] latched command selects the device function
// [R6] reset leaves the device in array read
// [R7] array read holds until a command changes
// [R8] load strobe latches the full start address
// [R9] advance with output enable high steps silently
// [R10] advance with output enable low drives next word
// [R11] select high ends burst, floats data pins
// [R12] new load abandons the running burst
// [R13] suspend floats pins, keeps word and position
// [R14] resume with advance high repeats held word
// [R15] resume with advance low outputs next word
// [R16] pins float in reset, write, output disable
// [R17] async mode ignores clock and burst strobes
// [R18] 5-bit counter clears, flags last, then wraps
// [R19] advance high freezes position and word
// [R20] only disable command or reset leaves burst
package flash_bus_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 5;
    localparam int BUF_N  = 2;
    // command codes on the low data byte
    localparam logic [7:0] CMD_BURST_EN  = 8'hC0;
    localparam logic [7:0] CMD_BURST_DIS = 8'hC8;
    localparam logic [7:0] CMD_RESET     = 8'hF0;
    localparam logic [4:0] CNT_RST  = 5'h00;
    localparam logic [4:0] CNT_LAST = 5'h1F;
    localparam logic [1:0] FILL_RST = 2'h0;
    localparam logic [1:0] FILL_MAX = 2'h2;
    typedef enum logic [0:0] {MODE_ARRAY, MODE_OTHER} mode_t;
endpackage : flash_bus_pkg

// ===== hw/burst_flash_bus_decoder.sv
// bus operation decoder for a 16-bit burst flash
// assumes host pins synchronous to sys_clk, array answers on a port
`timescale 1ns/1ps
module burst_flash_bus_decoder #(
    parameter int ADDR_W = flash_bus_pkg::ADDR_W,
    parameter int DATA_W = flash_bus_pkg::DATA_W,
    parameter int CNT_W  = flash_bus_pkg::CNT_W
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              chipSelN,
    input  wire logic              outEnN,
    input  wire logic              wrEnN,
    input  wire logic [ADDR_W-1:0] addrIn,
    input  wire logic [DATA_W-1:0] dataPinsIn,
    input  wire logic              loadStartAddrN,
    input  wire logic              advanceAddrN,
    input  wire logic              arrayRdValid,
    input  wire logic [DATA_W-1:0] arrayRdData,
    output logic [DATA_W-1:0]      dataPinsOut,
    output logic                   dataPinsOe,
    output logic                   burstEndFlagN,
    output logic                   arrayRdReq,
    output logic [ADDR_W-1:0]      arrayRdAddr,
    output logic                   arrayRdReady,
    output logic                   cmdStrobe,
    output logic [ADDR_W-1:0]      cmdAddr,
    output logic [DATA_W-1:0]      cmdData
);

    // refuse shapes the logic cannot serve
    if (CNT_W != 5 || DATA_W < 8 || ADDR_W <= CNT_W)
    begin : g_chk
        $error("unsupported width parameters");
    end

    typedef struct packed {
        flash_bus_pkg::mode_t        mode;
        logic                        burstMode;
        logic                        live;
        logic [ADDR_W-1:0]           start;
        logic [CNT_W-1:0]            cnt;
        logic [CNT_W-1:0]            fcnt;
        logic                        pend;
        logic                        drop;
        logic                        popDue;
        logic [1:0][DATA_W-1:0]      mem;
        logic                        wrIdx;
        logic                        rdIdx;
        logic [1:0]                  fill;
        logic [DATA_W-1:0]           outWord;
        logic [DATA_W-1:0]           pinWord;
        logic                        pinOe;
        logic                        endN;
        logic                        wrPrev;
        logic                        cmdStb;
        logic [ADDR_W-1:0]           cmdA;
        logic [DATA_W-1:0]           cmdD;
        logic                        rdReq;
        logic [ADDR_W-1:0]           rdAddr;
        logic                        rdReady;
    } state_t;

    localparam state_t STATE_RST = '{
        mode:    flash_bus_pkg::MODE_ARRAY,
        cnt:     flash_bus_pkg::CNT_RST,
        fcnt:    flash_bus_pkg::CNT_RST,
        fill:    flash_bus_pkg::FILL_RST,
        endN:    1'b1,
        rdReady: 1'b1,
        default: '0
    };

    state_t stateReg;
    state_t stateNext;

    // word address inside the wrapping 32-word window
    function automatic logic [ADDR_W-1:0] wrapAddr(
        input logic [ADDR_W-1:0] base,
        input logic [CNT_W-1:0]  step
    );
        logic [CNT_W-1:0] low;
        low = base[CNT_W-1:0] + step;
        return {base[ADDR_W-1:CNT_W], low};
    endfunction : wrapAddr

    // bus cycle decode
    logic sel;
    logic wrCyc;
    logic rdCyc;
    logic cmdEv;
    logic ldEv;
    logic advEv;
    logic asyncLd;
    assign sel   = !chipSelN;
    assign wrCyc = sel && outEnN && !wrEnN;
    assign rdCyc = sel && !outEnN && wrEnN;
    assign cmdEv = wrCyc && !stateReg.wrPrev;
    // strobes count only in burst mode
    assign ldEv  = stateReg.burstMode && sel && wrEnN   // R17
                   && !loadStartAddrN && advanceAddrN;
    assign advEv = stateReg.burstMode && stateReg.live && sel && wrEnN
                   && loadStartAddrN && !advanceAddrN;  // R19
    assign asyncLd = !stateReg.burstMode && rdCyc
                   && stateReg.mode == flash_bus_pkg::MODE_ARRAY
                   && (addrIn != stateReg.start || !stateReg.live);

    // next state of the whole decoder
    always_comb
    begin
        stateNext        = stateReg;
        stateNext.rdReq  = 1'b0;
        stateNext.cmdStb = 1'b0;
        stateNext.wrPrev = wrCyc;

        // command latch, never an array write
        if (cmdEv)
        begin
            stateNext.cmdStb = 1'b1;                // R3 R4
            stateNext.cmdA   = addrIn;
            stateNext.cmdD   = dataPinsIn;
            case (dataPinsIn[7:0])                  // R5
                flash_bus_pkg::CMD_BURST_EN:
                    stateNext.burstMode = 1'b1;
                flash_bus_pkg::CMD_BURST_DIS:
                begin
                    stateNext.burstMode = 1'b0;     // R20
                    stateNext.live      = 1'b0;
                end
                flash_bus_pkg::CMD_RESET:
                    stateNext.mode = flash_bus_pkg::MODE_ARRAY; // R20
                default:
                    stateNext.mode = flash_bus_pkg::MODE_OTHER; // R7
            endcase
        end

        // array answer lands in the buffer
        if (arrayRdValid && stateReg.pend)
        begin
            stateNext.pend = 1'b0;
            if (stateReg.drop)
                stateNext.drop = 1'b0;              // stale word
            else
            begin
                stateNext.mem[stateReg.wrIdx] = arrayRdData;
                stateNext.wrIdx = !stateReg.wrIdx;
                stateNext.fill  = stateNext.fill + 2'h1;
            end
        end

        // deselect ends the burst
        if (!sel)
        begin
            stateNext.live   = 1'b0;                // R11
            stateNext.popDue = 1'b0;
        end

        // start of a burst or of an async read
        if (ldEv || asyncLd)
        begin
            stateNext.start  = addrIn;              // R8 R12
            stateNext.live   = 1'b1;
            stateNext.fcnt   = flash_bus_pkg::CNT_RST;
            stateNext.fill   = flash_bus_pkg::FILL_RST;
            stateNext.wrIdx  = 1'b0;
            stateNext.rdIdx  = 1'b0;
            stateNext.drop   = stateNext.pend;
            stateNext.popDue = 1'b1;
            if (ldEv)
                stateNext.cnt = flash_bus_pkg::CNT_RST; // R18
        end
        else if (advEv)
        begin
            stateNext.cnt    = stateReg.cnt + 5'h01; // R9 R10 R15 R18
            stateNext.popDue = 1'b1;
        end

        // receiver takes the head word only when owed one
        if (stateNext.popDue && stateNext.fill != flash_bus_pkg::FILL_RST)
        begin
            stateNext.outWord = stateNext.mem[stateNext.rdIdx];
            stateNext.rdIdx   = !stateNext.rdIdx;
            stateNext.fill    = stateNext.fill - 2'h1;
            stateNext.popDue  = 1'b0;
        end

        // prefetch while the buffer has room
        if (stateNext.live && !stateNext.pend
            && stateNext.fill != flash_bus_pkg::FILL_MAX)
        begin
            stateNext.rdReq  = 1'b1;
            stateNext.rdAddr = wrapAddr(stateNext.start, stateNext.fcnt);
            stateNext.fcnt   = stateNext.fcnt + 5'h01;
            stateNext.pend   = 1'b1;
        end
        stateNext.rdReady = stateNext.fill != flash_bus_pkg::FILL_MAX;

        // pin drive follows a read cycle only: select and output enable low, write enable high
        stateNext.pinOe   = rdCyc;                  // R2 R13 R14 R16
        stateNext.pinWord =
            (stateNext.mode == flash_bus_pkg::MODE_ARRAY)
            ? stateNext.outWord : stateNext.cmdD;   // R6
        stateNext.endN = !(stateNext.burstMode && stateNext.live
                         && stateNext.cnt == flash_bus_pkg::CNT_LAST);
    end

    // state register, reset to array read
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            stateReg <= STATE_RST;                  // R6 R16 R20
        else
            stateReg <= stateNext;
    end

    // outputs straight from the state register
    assign dataPinsOut   = stateReg.pinWord;
    assign dataPinsOe    = stateReg.pinOe;
    assign burstEndFlagN = stateReg.endN;
    assign arrayRdReq    = stateReg.rdReq;
    assign arrayRdAddr   = stateReg.rdAddr;
    assign arrayRdReady  = stateReg.rdReady;
    assign cmdStrobe     = stateReg.cmdStb;
    assign cmdAddr       = stateReg.cmdA;
    assign cmdData       = stateReg.cmdD;

    // checks
    property p_oe_only_low;
        @(posedge sys_clk) disable iff (!nrst)
        dataPinsOe |-> $past(!outEnN) && $past(wrEnN);
    endproperty
    a_oe_only_low: assert property (p_oe_only_low) // R2
        else $error("pins driven without output enable");

    property p_float_disable;
        @(posedge sys_clk) disable iff (!nrst)
        (chipSelN || outEnN || !wrEnN) |=> !dataPinsOe;
    endproperty
    a_float_disable: assert property (p_float_disable) // R16
        else $error("pins driven while deselected or disabled");

    property p_cmd_capture;
        @(posedge sys_clk) disable iff (!nrst)
        cmdEv |=> cmdStrobe && cmdData == $past(dataPinsIn)
                  && cmdAddr == $past(addrIn) ##1 !cmdStrobe;
    endproperty
    a_cmd_capture: assert property (p_cmd_capture) // R3
        else $error("command latch missed a write");

    property p_array_stays;
        @(posedge sys_clk) disable iff (!nrst)
        stateReg.mode == flash_bus_pkg::MODE_ARRAY && !cmdEv
        |=> stateReg.mode == flash_bus_pkg::MODE_ARRAY;
    endproperty
    a_array_stays: assert property (p_array_stays) // R7
        else $error("left array read without a command");

    property p_load_clears;
        @(posedge sys_clk) disable iff (!nrst)
        ldEv |=> stateReg.cnt == flash_bus_pkg::CNT_RST
                 && stateReg.start == $past(addrIn) && stateReg.live;
    endproperty
    a_load_clears: assert property (p_load_clears) // R8
        else $error("load did not restart the burst");

    property p_adv_steps;
        @(posedge sys_clk) disable iff (!nrst)
        advEv && !ldEv |=> stateReg.cnt == $past(stateReg.cnt) + 5'h01;
    endproperty
    a_adv_steps: assert property (p_adv_steps) // R9
        else $error("advance did not step the counter");

    property p_hold;
        @(posedge sys_clk) disable iff (!nrst)
        stateReg.burstMode && advanceAddrN && loadStartAddrN
        && !stateReg.popDue |=> $stable(stateReg.cnt)
                               && $stable(stateReg.outWord);
    endproperty
    a_hold: assert property (p_hold) // R19
        else $error("burst moved with advance high");

    property p_wrap;
        @(posedge sys_clk) disable iff (!nrst)
        !burstEndFlagN && advEv && !ldEv
        |=> stateReg.cnt == flash_bus_pkg::CNT_RST && burstEndFlagN;
    endproperty
    a_wrap: assert property (p_wrap) // R18
        else $error("end flag or wrap wrong");

    property p_async_ignore;
        @(posedge sys_clk) disable iff (!nrst)
        !stateReg.burstMode |=> $stable(stateReg.cnt);
    endproperty
    a_async_ignore: assert property (p_async_ignore) // R17
        else $error("burst strobes acted in async mode");

    property p_reset_cmd_keeps;
        @(posedge sys_clk) disable iff (!nrst)
        cmdEv && stateReg.burstMode
        && dataPinsIn[7:0] == flash_bus_pkg::CMD_RESET |=> stateReg.burstMode;
    endproperty
    a_reset_cmd_keeps: assert property (p_reset_cmd_keeps) // R20
        else $error("reset command left burst mode");

    property p_deselect_ends;
        @(posedge sys_clk) disable iff (!nrst)
        chipSelN |=> !stateReg.live ##0 !dataPinsOe;
    endproperty
    a_deselect_ends: assert property (p_deselect_ends) // R11
        else $error("burst survived deselect");

    property p_adv_drives;
        @(posedge sys_clk) disable iff (!nrst)
        advEv && rdCyc && stateReg.mode == flash_bus_pkg::MODE_ARRAY
        && stateReg.fill != flash_bus_pkg::FILL_RST
        |=> dataPinsOe && dataPinsOut == $past(stateReg.mem[stateReg.rdIdx]);
    endproperty
    a_adv_drives: assert property (p_adv_drives) // R10
        else $error("advance did not drive the next word");

    property p_resume_same;
        @(posedge sys_clk) disable iff (!nrst)
        stateReg.burstMode && rdCyc && advanceAddrN && loadStartAddrN
        && !stateReg.popDue && stateReg.mode == flash_bus_pkg::MODE_ARRAY
        |=> dataPinsOe && dataPinsOut == $past(stateReg.outWord);
    endproperty
    a_resume_same: assert property (p_resume_same) // R14
        else $error("resume changed the held word");

    property p_new_load;
        @(posedge sys_clk) disable iff (!nrst)
        ldEv |=> stateReg.fill == flash_bus_pkg::FILL_RST && stateReg.popDue
                 && stateReg.rdIdx == 1'b0;
    endproperty
    a_new_load: assert property (p_new_load) // R12
        else $error("load kept words of the old burst");

    c_load: cover property (@(posedge sys_clk) disable iff (!nrst)
        ldEv ##[1:12] advEv);
    c_wrap: cover property (@(posedge sys_clk) disable iff (!nrst)
        !burstEndFlagN && advEv);
    c_resume: cover property (@(posedge sys_clk) disable iff (!nrst)
        (stateReg.live && outEnN && advanceAddrN) ##1 (!outEnN));
    c_reload: cover property (@(posedge sys_clk) disable iff (!nrst)
        ldEv && stateReg.live);

endmodule : burst_flash_bus_decoder

// ===== testbench/flash_array_model.sv
// array side model: answers each fetch, promptly or two cycles late
// assumes one outstanding fetch and the sys_clk domain of the decoder
`timescale 1ns/1ps
module flash_array_model (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        req,
    input  wire logic [18:0] addr,
    input  wire logic        slow,
    output logic             valid,
    output logic [15:0]      data
);
    logic [18:0] addrReg;
    logic [1:0]  waitReg;
    logic        busyReg;
    // answer pulse, data toggles between answers
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            valid <= 1'b0;
            busyReg <= 1'b0;
            data <= 16'hFFFF;
        end
        else
        begin
            valid <= 1'b0;
            data <= ~data;
            if (req && !slow)
            begin
                valid <= 1'b1;
                data <= 16'h5A3C ^ addr[15:0] ^ {13'h0000, addr[18:16]};
            end
            else if (req)
            begin
                addrReg <= addr;
                waitReg <= 2'h1;
                busyReg <= 1'b1;
            end
            else if (busyReg && waitReg != 2'h0)
                waitReg <= waitReg - 2'h1;
            else if (busyReg)
            begin
                valid <= 1'b1;
                busyReg <= 1'b0;
                data <= 16'h5A3C ^ addrReg[15:0] ^ {13'h0000, addrReg[18:16]};
            end
        end
    end
endmodule : flash_array_model

// ===== testbench/tb_burst_flash_bus_decoder.sv
// self-checking bench for the burst flash bus decoder
// assumes flash_array_model on the array port, one 125 MHz clock
`timescale 1ns/1ps
module tb_burst_flash_bus_decoder;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        csN = 1'b1;
    logic        oeN = 1'b1;
    logic        weN = 1'b1;
    logic        lbaN = 1'b1;
    logic        baaN = 1'b1;
    logic        slow = 1'b0;
    logic [18:0] addrIn = 19'h00000;
    logic [15:0] dIn = 16'h0000;
    logic [15:0] pinsOut, cmdData, rdData;
    logic [18:0] rdAddr, cmdAddr, a;
    logic        pinsOe, endN, rdReq, rdReady, cmdStb, rdValid;
    logic [31:0] seed = 32'h764063ED;
    int          n_errors = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          k;

    burst_flash_bus_decoder i_dut (.sys_clk(sys_clk), .nrst(nrst),
        .chipSelN(csN), .outEnN(oeN), .wrEnN(weN), .addrIn(addrIn),
        .dataPinsIn(dIn), .loadStartAddrN(lbaN), .advanceAddrN(baaN),
        .arrayRdValid(rdValid), .arrayRdData(rdData),
        .dataPinsOut(pinsOut), .dataPinsOe(pinsOe), .burstEndFlagN(endN),
        .arrayRdReq(rdReq), .arrayRdAddr(rdAddr), .arrayRdReady(rdReady),
        .cmdStrobe(cmdStb), .cmdAddr(cmdAddr), .cmdData(cmdData));
    flash_array_model i_array (.sys_clk(sys_clk), .nrst(nrst),
        .req(rdReq), .addr(rdAddr), .slow(slow), .valid(rdValid),
        .data(rdData));

    // clock and hang guard
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_errors++;
            $display("BAD %0t run did not finish", $time);
            final_report();
        end
    end

    function automatic logic [15:0] word_of(input logic [18:0] x);
        return 16'h5A3C ^ x[15:0] ^ {13'h0000, x[18:16]};
    endfunction : word_of
    function automatic logic [18:0] at(input logic [18:0] s, input int n);
        return {s[18:5], s[4:0] + n[4:0]};
    endfunction : at

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic tick();
        @(posedge sys_clk);
        #1;
        seed = lfsr_next(seed);
        slow = seed[3];
    endtask : tick
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    task automatic wait_word(input logic [15:0] exp, input logic fl);
        for (int i = 0; i < 12; i++)
        begin
            if (pinsOe === 1'b1 && pinsOut === exp)
                break;
            tick();
        end
        check(pinsOe === 1'b1 && pinsOut === exp && endN === fl, "word");
    endtask : wait_word
    task automatic floats();
        tick();
        tick();
        check(pinsOe === 1'b0, "pins driven");
    endtask : floats
    task automatic write_cmd(input logic [7:0] c);
        oeN = 1'b1;
        weN = 1'b0;
        dIn = {8'h00, c};
        tick();
        weN = 1'b1;
        for (int i = 0; i < 3 && cmdStb !== 1'b1; i++)
            tick();
        check(cmdStb === 1'b1 && cmdData === {8'h00, c}
              && cmdAddr === addrIn, "command");
        oeN = 1'b0;
    endtask : write_cmd
    task automatic load(input logic [18:0] x);
        addrIn = x;
        lbaN = 1'b0;
        tick();
        lbaN = 1'b1;
    endtask : load
    task automatic adv();
        baaN = 1'b0;
        tick();
        baaN = 1'b1;
        tick();
    endtask : adv
    task automatic final_report();
        if (n_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // main sequence
    initial
    begin
        repeat (20) @(posedge sys_clk);
        #1 nrst = 1'b1;
        check(pinsOe === 1'b0 && endN === 1'b1, "reset");
        csN = 1'b0;
        oeN = 1'b0;
        for (k = 0; k < 4; k++)
        begin
            addrIn = seed[18:0];
            lbaN = seed[20];
            baaN = seed[21];
            wait_word(word_of(addrIn), 1'b1);
        end
        lbaN = 1'b1;
        baaN = 1'b1;
        oeN = 1'b1;
        floats();
        write_cmd(8'h90);
        wait_word(16'h0090, 1'b1);
        write_cmd(flash_bus_pkg::CMD_RESET);
        addrIn = seed[18:0];
        wait_word(word_of(addrIn), 1'b1);
        write_cmd(flash_bus_pkg::CMD_BURST_EN);
        a = seed[18:0];
        load(a);
        wait_word(word_of(a), 1'b1);
        for (k = 1; k < 34; k++)
        begin
            adv();
            wait_word(word_of(at(a, k)), (k % 32) != 31);
        end
        oeN = 1'b1;
        floats();
        oeN = 1'b0;
        wait_word(word_of(at(a, 1)), 1'b1);
        repeat (3) tick();
        check(pinsOut === word_of(at(a, 1)), "held word moved");
        repeat (6) tick();
        check(rdReady === 1'b0 && pinsOut === word_of(at(a, 1)), "full");
        adv();
        wait_word(word_of(at(a, 2)), 1'b1);
        oeN = 1'b1;
        adv();
        floats();
        oeN = 1'b0;
        wait_word(word_of(at(a, 3)), 1'b1);
        load(at(a, 9) ^ 19'h40000);
        wait_word(word_of(at(a, 9) ^ 19'h40000), 1'b1);
        csN = 1'b1;
        floats();
        csN = 1'b0;
        write_cmd(flash_bus_pkg::CMD_RESET);
        load(a);
        wait_word(word_of(a), 1'b1);
        adv();
        wait_word(word_of(at(a, 1)), 1'b1);
        write_cmd(flash_bus_pkg::CMD_BURST_DIS);
        wait_word(word_of(a), 1'b1);
        repeat (3) adv();
        check(pinsOut === word_of(a) && endN === 1'b1, "strobes");
        nrst = 1'b0;
        #1 check(pinsOe === 1'b0 && endN === 1'b1, "in reset");
        tick();
        nrst = 1'b1;
        addrIn = seed[18:0];
        wait_word(word_of(addrIn), 1'b1);
        final_report();
    end
endmodule : tb_burst_flash_bus_decoder
